// ---- include/host_cmd_pkg.sv ----
package host_cmd_pkg;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RD_REG = 8'h04;
  localparam logic [7:0] OP_RD_MULTI = 8'h05;
  localparam logic [7:0] OP_EE_WR = 8'h06;
  localparam logic [7:0] OP_EE_RD = 8'h07;
  localparam logic [7:0] OP_TX_LOAD = 8'h08;

  // ----------------------------------------------------------------
  // limits and layout
  // ----------------------------------------------------------------
  localparam logic [8:0] MULTI_MAX = 9'h012;
  localparam int MULTI_SLOTS = 18;
  localparam logic [9:0] EE_LAST = 10'h0FE;
  localparam int EE_BYTES = 255;
  localparam logic [8:0] TX_BUF_BYTES = 9'h104;
  localparam int TX_BYTES = 260;
  localparam logic [8:0] REG_BYTES = 9'h004;
  localparam logic [8:0] CNT_MAX = 9'h1FF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] REG_COUNT_DEF = 8'h40;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // interpreter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_EXEC = 3'b010,
    ST_PREP = 3'b011,
    ST_LOAD = 3'b100,
    ST_RDY = 3'b101,
    ST_RESP = 3'b110
  } state_t;

endpackage

// ---- src/host_link.sv ----
`timescale 1ns/1ps
module host_link (
  input wire logic sck_in,
  input wire logic nss_n_in,
  input wire logic mosi_in,
  input wire logic rst_n_in,
  input wire logic [7:0] resp_in,
  output logic miso_out,
  output logic [7:0] rx_byte_out,
  output logic rx_tgl_out
);

  logic [2:0] bit_q, bit_d;
  logic [6:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic tgl_q, tgl_d;
  logic [7:0] tx_q, tx_d;
  logic miso_q, miso_d;

  // ----------------------------------------------------------------
  // shifting on the host clock, bit counter cleared by frame end
  // ----------------------------------------------------------------
  always_comb begin
    bit_d = bit_q + 3'h1;
    sh_d = {sh_q[5:0], mosi_in};
    rx_d = rx_q;
    tgl_d = tgl_q;
    if (bit_q == host_cmd_pkg::BIT_LAST) begin
      rx_d = {sh_q, mosi_in};
      tgl_d = ~tgl_q;
    end
    // response byte is held stable by the core until the toggle moves
    if (bit_q == 3'h0) begin
      miso_d = resp_in[7];
      tx_d = {resp_in[6:0], 1'b0};
    end else begin
      miso_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge sck_in or posedge nss_n_in) begin
    if (nss_n_in) begin
      bit_q <= 3'h0;
    end else begin
      bit_q <= bit_d;
    end
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_q <= 7'h00;
      rx_q <= 8'h00;
      tgl_q <= 1'b0;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      rx_q <= rx_d;
      tgl_q <= tgl_d;
      tx_q <= tx_d;
      miso_q <= miso_d;
    end
  end

  assign miso_out = miso_q;
  assign rx_byte_out = rx_q;
  assign rx_tgl_out = tgl_q;

endmodule

// ---- src/host_cmd_reg_eeprom_txbuf.sv ----
`timescale 1ns/1ps
module host_cmd_reg_eeprom_txbuf #(
  parameter logic [7:0] REG_COUNT = host_cmd_pkg::REG_COUNT_DEF
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sck_in,
  input wire logic nss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [7:0] reg_addr_out,
  input wire logic [31:0] reg_data_in,
  input wire logic tx_busy_in,
  output logic [8:0] tx_len_out,
  input wire logic [8:0] tx_rd_addr_in,
  output logic [7:0] tx_rd_data_out,
  output logic err_out,
  output logic busy_out
);

  host_cmd_pkg::state_t st_q, st_d;
  logic [7:0] op_q, op_d, addr_q, addr_d, len_q, len_d, resp_q, resp_d, raddr_q, raddr_d;
  logic [8:0] cnt_q, cnt_d, tot_q, tot_d, ptr_q, ptr_d, txlen_q, txlen_d;
  logic perr_q, perr_d, err_q, err_d, busy_q;
  logic [31:0] word_q, word_d, nxt_q;
  logic [7:0] list_q [host_cmd_pkg::MULTI_SLOTS];
  logic [7:0] list_d [host_cmd_pkg::MULTI_SLOTS];
  logic [7:0] ee_q [host_cmd_pkg::EE_BYTES];
  logic [7:0] tx_q [host_cmd_pkg::TX_BYTES];
  logic [7:0] txrd_q;
  logic ee_we, tx_we;
  logic [7:0] ee_wa;
  logic [8:0] tx_wa;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic tgl_s1, tgl_s2, tgl_s3, nss_s1, nss_s2, nss_s3;
  logic byte_ev, frame_start, frame_end;

  function automatic logic reg_exists(input logic [7:0] a);
    reg_exists = (a < REG_COUNT);
  endfunction

  // ----------------------------------------------------------------
  // host clock side
  // ----------------------------------------------------------------
  host_link u_link (
    .sck_in(sck_in),
    .nss_n_in(nss_n_in),
    .mosi_in(mosi_in),
    .rst_n_in(resetn_in),
    .resp_in(resp_q),
    .miso_out(miso_out),
    .rx_byte_out(rx_byte),
    .rx_tgl_out(rx_tgl)
  );

  // ----------------------------------------------------------------
  // crossings: byte toggle and frame select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      nss_s1 <= 1'b1;
      nss_s2 <= 1'b1;
      nss_s3 <= 1'b1;
    end else begin
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      nss_s1 <= nss_n_in;
      nss_s2 <= nss_s1;
      nss_s3 <= nss_s2;
    end
  end

  assign byte_ev = tgl_s2 ^ tgl_s3;
  assign frame_start = nss_s3 & ~nss_s2;
  assign frame_end = ~nss_s3 & nss_s2;

  // ----------------------------------------------------------------
  // interpreter
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] a10;
    logic [8:0] idx, p;
    logic [4:0] w1;
    logic ok;
    a10 = 10'h000;
    idx = 9'h000;
    p = 9'h000;
    w1 = 5'h00;
    ok = 1'b0;
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    len_d = len_q;
    perr_d = perr_q;
    err_d = err_q;
    tot_d = tot_q;
    ptr_d = ptr_q;
    word_d = word_q;
    resp_d = resp_q;
    raddr_d = raddr_q;
    txlen_d = txlen_q;
    list_d = list_q;
    ee_we = 1'b0;
    ee_wa = 8'h00;
    tx_we = 1'b0;
    tx_wa = 9'h000;
    case (st_q)
      host_cmd_pkg::ST_IDLE, host_cmd_pkg::ST_RDY: begin
        if (frame_start) begin
          st_d = (st_q == host_cmd_pkg::ST_RDY) ? host_cmd_pkg::ST_RESP : host_cmd_pkg::ST_RX;
          cnt_d = 9'h000;
          perr_d = 1'b0;
        end
      end
      host_cmd_pkg::ST_RX: begin
        if (byte_ev) begin
          cnt_d = (cnt_q == host_cmd_pkg::CNT_MAX) ? cnt_q : cnt_q + 9'h001;
          idx = cnt_q - 9'h001;
          if (cnt_q == 9'h000) begin
            op_d = rx_byte;
            err_d = 1'b0;
          end else begin
            case (op_q)
              host_cmd_pkg::OP_RD_REG, host_cmd_pkg::OP_RD_MULTI: begin
                if (!reg_exists(rx_byte)) begin
                  perr_d = 1'b1;
                end
                if (idx < host_cmd_pkg::MULTI_MAX) begin
                  list_d[idx[4:0]] = rx_byte;
                end else begin
                  perr_d = 1'b1;
                end
                if (op_q == host_cmd_pkg::OP_RD_REG && cnt_q != 9'h001) begin
                  perr_d = 1'b1;
                end
              end
              host_cmd_pkg::OP_EE_WR: begin
                if (cnt_q == 9'h001) begin
                  addr_d = rx_byte;
                end else begin
                  a10 = {2'b00, addr_q} + {1'b0, cnt_q} - 10'h002;
                  if (a10 <= host_cmd_pkg::EE_LAST && !perr_q) begin
                    ee_we = 1'b1;
                    ee_wa = a10[7:0];
                  end else begin
                    perr_d = 1'b1;
                  end
                end
              end
              host_cmd_pkg::OP_EE_RD: begin
                if (cnt_q == 9'h001) begin
                  addr_d = rx_byte;
                end else if (cnt_q == 9'h002) begin
                  len_d = rx_byte;
                end else begin
                  perr_d = 1'b1;
                end
              end
              host_cmd_pkg::OP_TX_LOAD: begin
                if (tx_busy_in || idx >= host_cmd_pkg::TX_BUF_BYTES) begin
                  perr_d = 1'b1;
                end else if (!perr_q) begin
                  tx_we = 1'b1;
                  tx_wa = idx;
                end
              end
              default: perr_d = 1'b1;
            endcase
          end
        end
        if (frame_end) begin
          st_d = (cnt_q == 9'h000) ? host_cmd_pkg::ST_IDLE : host_cmd_pkg::ST_EXEC;
        end
      end
      host_cmd_pkg::ST_EXEC: begin
        a10 = {2'b00, addr_q} + {2'b00, len_q} - 10'h001;
        case (op_q)
          host_cmd_pkg::OP_RD_REG: begin
            ok = (cnt_q == 9'h002) && !perr_q;
            tot_d = host_cmd_pkg::REG_BYTES;
          end
          host_cmd_pkg::OP_RD_MULTI: begin
            ok = (cnt_q >= 9'h002) && (cnt_q <= host_cmd_pkg::MULTI_MAX + 9'h001) && !perr_q;
            tot_d = {cnt_q[6:0] - 7'h01, 2'b00};
          end
          host_cmd_pkg::OP_EE_WR: ok = (cnt_q >= 9'h003) && !perr_q;
          host_cmd_pkg::OP_EE_RD: begin
            ok = (cnt_q == 9'h003) && (len_q != 8'h00) && (a10 <= host_cmd_pkg::EE_LAST);
            tot_d = {1'b0, len_q};
          end
          host_cmd_pkg::OP_TX_LOAD: begin
            ok = (cnt_q >= 9'h002) && !perr_q && !tx_busy_in;
            if (ok) begin
              txlen_d = cnt_q - 9'h001;
            end
          end
          default: ok = 1'b0;
        endcase
        ptr_d = 9'h000;
        st_d = host_cmd_pkg::ST_IDLE;
        if (!ok) begin
          err_d = 1'b1;
        end else if (op_q == host_cmd_pkg::OP_RD_REG || op_q == host_cmd_pkg::OP_RD_MULTI) begin
          raddr_d = list_q[0];
          st_d = host_cmd_pkg::ST_PREP;
        end else if (op_q == host_cmd_pkg::OP_EE_RD) begin
          resp_d = ee_q[addr_q];
          st_d = host_cmd_pkg::ST_RDY;
        end
      end
      host_cmd_pkg::ST_PREP: st_d = host_cmd_pkg::ST_LOAD;
      host_cmd_pkg::ST_LOAD: begin
        word_d = nxt_q;
        resp_d = nxt_q[7:0];
        raddr_d = list_q[1];
        st_d = host_cmd_pkg::ST_RDY;
      end
      host_cmd_pkg::ST_RESP: begin
        if (byte_ev) begin
          p = ptr_q + 9'h001;
          w1 = p[6:2] + 5'h01;
          ptr_d = p;
          if (p >= tot_q) begin
            resp_d = host_cmd_pkg::FILL_BYTE;
          end else if (op_q == host_cmd_pkg::OP_EE_RD) begin
            resp_d = ee_q[addr_q + p[7:0]];
          end else if (p[1:0] == 2'b00) begin
            word_d = nxt_q;
            resp_d = nxt_q[7:0];
            if (w1 < 5'(host_cmd_pkg::MULTI_SLOTS)) begin
              raddr_d = list_q[w1];
            end
          end else begin
            resp_d = word_q[{p[1:0], 3'b000} +: 8];
          end
        end
        if (frame_end) begin
          st_d = host_cmd_pkg::ST_IDLE;
        end
      end
      default: st_d = host_cmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q <= host_cmd_pkg::ST_IDLE;
      op_q <= 8'h00;
      cnt_q <= 9'h000;
      addr_q <= 8'h00;
      len_q <= 8'h00;
      perr_q <= 1'b0;
      err_q <= 1'b0;
      tot_q <= 9'h000;
      ptr_q <= 9'h000;
      word_q <= 32'h0000_0000;
      resp_q <= host_cmd_pkg::FILL_BYTE;
      raddr_q <= 8'h00;
      txlen_q <= 9'h000;
      busy_q <= 1'b0;
      for (int i = 0; i < host_cmd_pkg::MULTI_SLOTS; i++) begin
        list_q[i] <= 8'h00;
      end
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      len_q <= len_d;
      perr_q <= perr_d;
      err_q <= err_d;
      tot_q <= tot_d;
      ptr_q <= ptr_d;
      word_q <= word_d;
      resp_q <= resp_d;
      raddr_q <= raddr_d;
      txlen_q <= txlen_d;
      busy_q <= (st_d == host_cmd_pkg::ST_EXEC) || (st_d == host_cmd_pkg::ST_PREP)
        || (st_d == host_cmd_pkg::ST_LOAD);
      list_q <= list_d;
    end
  end

  // ----------------------------------------------------------------
  // storage: nonvolatile image, transmit buffer, register prefetch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    nxt_q <= reg_data_in;
    if (ee_we) begin
      ee_q[ee_wa] <= rx_byte;
    end
    if (tx_we) begin
      tx_q[tx_wa] <= rx_byte;
    end
    if (tx_rd_addr_in < host_cmd_pkg::TX_BUF_BYTES) begin
      txrd_q <= tx_q[tx_rd_addr_in];
    end else begin
      txrd_q <= 8'h00;
    end
  end

  assign reg_addr_out = raddr_q;
  assign tx_len_out = txlen_q;
  assign tx_rd_data_out = txrd_q;
  assign err_out = err_q;
  assign busy_out = busy_q;

endmodule

// ---- verif/host_cmd_assertions.sv ----
`timescale 1ns/1ps
module host_cmd_assertions (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic nss_n_in,
  input wire logic tx_busy_in,
  input wire logic [8:0] tx_rd_addr_in,
  input wire logic [7:0] tx_rd_data_out,
  input wire logic [8:0] tx_len_out,
  input wire logic err_out,
  input wire logic busy_out
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_rst; disable iff (1'b0) !resetn_in |=> !err_out && !busy_out && tx_len_out == 9'h000; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_busy_len; busy_out |-> ##[1:5] !busy_out; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  property p_busy_end; $rose(busy_out) |-> nss_n_in; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy inside frame");
  property p_err_set; $rose(err_out) |-> nss_n_in && $past(nss_n_in); endproperty
  a_err_set: assert property (p_err_set) else $error("error raised inside frame");
  property p_err_clr; $fell(err_out) |-> !nss_n_in; endproperty
  a_err_clr: assert property (p_err_clr) else $error("error cleared outside frame");
  property p_txd_zero; tx_rd_addr_in >= 9'h104 |=> tx_rd_data_out == 8'h00; endproperty
  a_txd_zero: assert property (p_txd_zero) else $error("buffer read past end not zero");
  property p_len_rng; $past(resetn_in) && $changed(tx_len_out) |-> tx_len_out inside {[9'h001:9'h104]}; endproperty
  a_len_rng: assert property (p_len_rng) else $error("load length out of range");
  property p_len_busy; tx_busy_in && $past(tx_busy_in) |-> $stable(tx_len_out); endproperty
  a_len_busy: assert property (p_len_busy) else $error("load taken during transmission");
endmodule

// ---- verif/host_spi_model.sv ----
`timescale 1ns/1ps
module host_spi_model (
  output logic sck_out,
  output logic nss_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  initial begin
    sck_out = 1'b0;
    nss_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame: shift tx_q out, collect rx_q
  // ----------------------------------------------------------------
  task automatic frame();
    logic [7:0] b;
    rx_q = {};
    nss_n_out = 1'b0;
    #100;
    foreach (tx_q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_out = tx_q[i][k];
        #62.5 sck_out = 1'b1;
        #62.5 sck_out = 1'b0;
        b[k] = miso_in;
      end
      rx_q.push_back(b);
    end
    mosi_out = ~mosi_out;
    #100 nss_n_out = 1'b1;
    #250;
  endtask
endmodule

// ---- verif/test_host_cmd_reg_eeprom_txbuf.sv ----
`timescale 1ns/1ps
module test_host_cmd_reg_eeprom_txbuf;
  logic clk_in, resetn_in, sck, nss_n, mosi, miso, tx_busy_in, err_out, busy_out;
  logic [7:0] reg_addr_out, tx_rd_data_out;
  logic [8:0] tx_len_out, tx_rd_addr_in;
  logic [31:0] reg_data_in;
  int miscompares, samples_checked;

  function automatic logic [31:0] reg_val(logic [7:0] a);
    return {a ^ 8'h3C, ~a, a, 8'hA5};
  endfunction

  assign reg_data_in = reg_val(reg_addr_out);

  host_cmd_reg_eeprom_txbuf i_dut (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sck_in(sck),
    .nss_n_in(nss_n),
    .mosi_in(mosi),
    .miso_out(miso),
    .reg_addr_out(reg_addr_out),
    .reg_data_in(reg_data_in),
    .tx_busy_in(tx_busy_in),
    .tx_len_out(tx_len_out),
    .tx_rd_addr_in(tx_rd_addr_in),
    .tx_rd_data_out(tx_rd_data_out),
    .err_out(err_out),
    .busy_out(busy_out)
  );

  host_spi_model i_host (
    .sck_out(sck),
    .nss_n_out(nss_n),
    .mosi_out(mosi),
    .miso_in(miso)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(logic [7:0] q[$]);
    i_host.tx_q = q;
    i_host.frame();
    for (int i = 0; i < 20 && busy_out !== 1'b0; i++) @(negedge clk_in);
    check("busy end", busy_out, 1'b0);
  endtask

  task automatic send_err(logic [7:0] q[$]);
    send(q);
    check("err set", err_out, 1'b1);
  endtask

  task automatic get(int n);
    i_host.tx_q = {};
    repeat (n) i_host.tx_q.push_back(8'h00);
    i_host.frame();
  endtask

  task automatic chk_word(int off, logic [7:0] a);
    logic [31:0] v;
    v = reg_val(a);
    for (int k = 0; k < 4; k++) check("reg byte", i_host.rx_q[off + k], v[8 * k +: 8]);
  endtask

  task automatic rd_buf(logic [8:0] a, logic [7:0] exp);
    @(negedge clk_in);
    tx_rd_addr_in = a;
    @(negedge clk_in);
    check("tx buf", tx_rd_data_out, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_rd_reg();
    for (int a = 0; a < 64; a += 63) begin
      send({8'h04, 8'(a)});
      check("err clear", err_out, 1'b0);
      get(4);
      chk_word(0, 8'(a));
    end
  endtask

  task automatic t_multi();
    logic [7:0] ad[$];
    ad = {8'h3F, 8'h02, 8'h10, 8'h02};
    send({8'h05, ad});
    get(17);
    foreach (ad[j]) chk_word(4 * j, ad[j]);
    check("no extra", i_host.rx_q[16], 8'hFF);
    ad = {};
    for (int j = 17; j >= 0; j--) ad.push_back(8'(j));
    send({8'h05, ad});
    check("err 18", err_out, 1'b0);
    get(72);
    chk_word(0, 8'h11);
    chk_word(68, 8'h00);
  endtask

  task automatic t_err();
    logic [7:0] q[$];
    q = {8'h05};
    repeat (19) q.push_back(8'h01);
    send_err(q);
    send_err({8'h05});
    send_err({8'h04, 8'h40});
    send_err({8'h06, 8'hFF, 8'h01});
    send_err({8'h06, 8'h00});
    send_err({8'h07, 8'hFE, 8'h02});
    send_err({8'h07, 8'hFF, 8'h01});
    send_err({8'h08});
    send_err({8'h0C});
  endtask

  task automatic t_ee();
    send({8'h06, 8'hFC, 8'h11, 8'h22, 8'h33});
    check("ee wr", err_out, 1'b0);
    send({8'h07, 8'hFC, 8'h03});
    get(3);
    for (int k = 0; k < 3; k++) check("ee rd", i_host.rx_q[k], 8'(8'h11 * (k + 1)));
    send_err({8'h06, 8'hFE, 8'h44, 8'h55});
    send({8'h07, 8'hFE, 8'h01});
    check("ee last", err_out, 1'b0);
    get(1);
    check("ee keep", i_host.rx_q[0], 8'h44);
  endtask

  task automatic t_tx();
    logic [7:0] q[$];
    send({8'h08, 8'hA1, 8'hB2, 8'hC3});
    check("tx len", tx_len_out, 9'h003);
    rd_buf(9'h000, 8'hA1);
    rd_buf(9'h002, 8'hC3);
    q = {8'h08};
    for (int i = 0; i < 260; i++) q.push_back(8'(i));
    send(q);
    check("tx full", tx_len_out, 9'h104);
    rd_buf(9'h103, 8'h03);
    rd_buf(9'h104, 8'h00);
    @(negedge clk_in);
    tx_busy_in = 1'b1;
    send_err({8'h08, 8'h55});
    check("tx len kept", tx_len_out, 9'h104);
    @(negedge clk_in);
    tx_busy_in = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  initial begin
    resetn_in = 1'b0;
    tx_busy_in = 1'b0;
    tx_rd_addr_in = 9'h000;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    check("rst err", err_out, 1'b0);
    check("rst len", tx_len_out, 9'h000);
    repeat (4) @(negedge clk_in);
    t_rd_reg();
    t_multi();
    t_err();
    t_ee();
    t_tx();
    // mid-run reset while the error flag and load length are set
    @(negedge clk_in);
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    check("rerst err", err_out, 1'b0);
    check("rerst len", tx_len_out, 9'h000);
    repeat (4) @(negedge clk_in);
    send({8'h08, 8'h5A});
    check("tx len again", tx_len_out, 9'h001);
    rd_buf(9'h000, 8'h5A);
    end_of_test();
  end

  initial begin
    #1500000;
    miscompares++;
    end_of_test();
  end
endmodule

bind host_cmd_reg_eeprom_txbuf host_cmd_assertions i_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .nss_n_in(nss_n_in),
  .tx_busy_in(tx_busy_in),
  .tx_rd_addr_in(tx_rd_addr_in),
  .tx_rd_data_out(tx_rd_data_out),
  .tx_len_out(tx_len_out),
  .err_out(err_out),
  .busy_out(busy_out)
);
